// file: rtl/sltx_sequencer.sv
// Purpose: Table-driven transmit sequencer of a synchronous line unit.
// Assumes: Modem clock and status pins are asynchronous to clk_sys_i.
// Notes:   Sync buffer strobes on leading edges of the synced modem clock.
module sltx_sequencer
    import sltx_pkg::*;
(
    // Clock and reset
    input  wire logic               clk_sys_i,
    input  wire logic               rst_i,
    // Modem and switches
    input  wire logic               tx_clk_i,
    input  wire logic               clear_to_send_i,
    input  wire logic               data_set_ready_i,
    input  wire logic               crc_disable_i,
    input  wire logic               table_disable_test_i,
    output logic                    serial_tx_o,
    // AXI4-Lite write
    input  wire logic [SLTX_AW-1:0] s_axi_awaddr_i,
    input  wire logic               s_axi_awvalid_i,
    output logic                    s_axi_awready_o,
    input  wire logic [31:0]        s_axi_wdata_i,
    input  wire logic [3:0]         s_axi_wstrb_i,
    input  wire logic               s_axi_wvalid_i,
    output logic                    s_axi_wready_o,
    output logic [1:0]              s_axi_bresp_o,
    output logic                    s_axi_bvalid_o,
    input  wire logic               s_axi_bready_i,
    // AXI4-Lite read
    input  wire logic [SLTX_AW-1:0] s_axi_araddr_i,
    input  wire logic               s_axi_arvalid_i,
    output logic                    s_axi_arready_o,
    output logic [31:0]             s_axi_rdata_o,
    output logic [1:0]              s_axi_rresp_o,
    output logic                    s_axi_rvalid_o,
    input  wire logic               s_axi_rready_i
);
    // ========================================================================
    // Tables as fixed combinational functions
    // Function table address: proto, no_crc, send, act, flag, edge, eom, load
    function automatic sltx_fd_s function_decode_table(input logic [7:0] a);
        sltx_fd_s o;
        o = '0;
        o.flag_request     = a[5] & a[0] & (~a[4] | a[1]);
        o.check_request    = a[0] & a[4] & a[1] & ~a[6];
        o.activate_request = a[5];
        o.done_preset      = a[0] & a[4] & ~a[1] & ~a[3];
        return o;
    endfunction : function_decode_table

    // Path table address: proto, abort, flag, crc, 0, ones6, ones5, load
    function automatic sltx_pc_s path_control_table(input logic [7:0] a);
        sltx_pc_s o;
        logic     stuff;
        o     = '0;
        stuff = ~a[7] & a[1] & ~a[5] & ~a[6];
        o.space_insert       = stuff;
        o.check_select       = a[4] & ~a[5] & ~a[6] & ~stuff;
        o.shift_select       = ~a[5] & ~a[4] & ~a[6] & ~stuff;
        o.bit_counter_enable = ~stuff;
        return o;
    endfunction : path_control_table

    // Data table address: som, load, space, 0, crcsel, crcout, srsel, srout
    function automatic sltx_dd_s data_decode_table(input logic [7:0] a);
        sltx_dd_s o;
        o = '0;
        o.buffer_to_shift_load  = a[6] & a[1] & ~a[5];
        o.shift_clock_qualifier = a[1] & ~a[5] & ~(a[6] & a[1]);
        o.crc_clock_enable      = ~a[5] & (a[1] | a[3]);
        if (a[5]) begin
            o.serial_tx_bit = 1'b0;
        end else if (a[3]) begin
            o.serial_tx_bit = a[2];
        end else if (a[1]) begin
            o.serial_tx_bit = a[0];
        end else begin
            o.serial_tx_bit = 1'b1;
        end
        return o;
    endfunction : data_decode_table

    // ========================================================================
    // State
    typedef struct packed {
        logic [1:0]  txc_sync;
        logic        txc_prev;
        logic [1:0]  cts_sync;
        logic [1:0]  dsr_sync;
        logic [1:0]  nocrc_sync;
        logic [1:0]  dis_sync;
        logic        proto_ddcmp;
        sltx_sync_s  sb;
        logic [2:0]  bit_count;
        logic [2:0]  ones;
        logic [7:0]  shreg;
        logic [9:0]  hold;
        logic        hold_full;
        logic        tx_done;
        logic        data_late;
        logic [15:0] crc;
        logic        txd;
        sltx_wr_e    wr_state;
        logic        aw_got;
        logic        w_got;
        logic [3:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } sltx_state_s;

    sltx_state_s  s;
    sltx_state_s  next_s;
    sltx_fd_s     fd;
    sltx_pc_s     pc;
    sltx_dd_s     dd;
    sltx_status_s status;
    logic         bit_edge;
    logic         send_permit;
    logic         frame_edge_pending;
    logic         char_last_bit_pulse;
    logic         load;
    logic         sync_buffer_strobe;
    logic         tables_off;
    logic         ones_run_five;
    logic         ones_run_six;
    logic         crc_fb;
    logic         wr_go;
    logic         wr_out;
    logic         wr_maint;

    // ========================================================================
    // Transmit control decode
    always_comb begin
        bit_edge           = s.txc_sync[1] & ~s.txc_prev;
        send_permit        = s.cts_sync[1] & s.dsr_sync[1];
        frame_edge_pending = s.sb.check_request | s.sb.start_of_message_bit;
        tables_off         = s.dis_sync[1];
        ones_run_five      = (s.ones >= SLTX_ONES_5);
        ones_run_six       = (s.ones >= SLTX_ONES_6);
        pc = path_control_table({s.proto_ddcmp, s.sb.synced_abort,
                                 s.sb.flag_request, s.sb.check_request,
                                 1'b0, ones_run_six, ones_run_five, 1'b0});
        char_last_bit_pulse = (s.bit_count == SLTX_BIT_MAX) & pc.bit_counter_enable;
        load = ~s.sb.synced_sending_flag | char_last_bit_pulse;
        pc = path_control_table({s.proto_ddcmp, s.sb.synced_abort,
                                 s.sb.flag_request, s.sb.check_request,
                                 1'b0, ones_run_six, ones_run_five, load});
        fd = function_decode_table({s.proto_ddcmp, s.nocrc_sync[1],
                                    send_permit, s.sb.synced_sending_flag,
                                    s.sb.flag_request, frame_edge_pending,
                                    s.hold[SLTX_EOM_BIT], load});
        dd = data_decode_table({s.sb.start_of_message_bit, load,
                                pc.space_insert, 1'b0, pc.check_select,
                                s.crc[15], pc.shift_select, s.shreg[0]});
        if (tables_off) begin
            fd = '0;
            dd = '0;
        end
        sync_buffer_strobe = bit_edge & load;
    end

    // ========================================================================
    // Bus decode
    always_comb begin
        s_axi_awready_o = (s.wr_state == SLTX_WR_COLLECT) & ~s.aw_got;
        s_axi_wready_o  = (s.wr_state == SLTX_WR_COLLECT) & ~s.w_got;
        s_axi_bvalid_o  = (s.wr_state == SLTX_WR_RESP);
        s_axi_bresp_o   = s.bresp;
        s_axi_arready_o = ~s.rvalid;
        s_axi_rvalid_o  = s.rvalid;
        s_axi_rdata_o   = s.rdata;
        s_axi_rresp_o   = s.rresp;
        serial_tx_o     = s.txd;
        wr_go    = (s.wr_state == SLTX_WR_COLLECT) & s.aw_got & s.w_got;
        wr_out   = wr_go & (s.awaddr == SLTX_OUT_OFS) & s.wstrb[0];
        wr_maint = wr_go & (s.awaddr == SLTX_MAINT_OFS) & s.wstrb[0];
        status = '0;
        status.sync_buffer   = s.sb;
        status.serial_tx_bit = s.txd;
        status.tx_done       = s.tx_done;
        status.data_late     = s.data_late;
        status.hold_full     = s.hold_full;
        status.bit_count     = s.bit_count;
        status.ones          = s.ones;
    end

    // ========================================================================
    // Next state
    always_comb begin
        next_s          = s;
        next_s.txc_sync = {s.txc_sync[0], tx_clk_i};
        next_s.txc_prev = s.txc_sync[1];
        next_s.cts_sync = {s.cts_sync[0], clear_to_send_i};
        next_s.dsr_sync = {s.dsr_sync[0], data_set_ready_i};
        next_s.nocrc_sync = {s.nocrc_sync[0], crc_disable_i};
        next_s.dis_sync = {s.dis_sync[0], table_disable_test_i};
        crc_fb = 1'b0;

        // Write channel: address and data in either order
        if (s_axi_awvalid_i & s_axi_awready_o) begin
            next_s.aw_got = 1'b1;
            next_s.awaddr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i & s_axi_wready_o) begin
            next_s.w_got = 1'b1;
            next_s.wdata = s_axi_wdata_i;
            next_s.wstrb = s_axi_wstrb_i;
        end
        if (wr_go) begin
            next_s.wr_state = SLTX_WR_RESP;
            next_s.aw_got   = 1'b0;
            next_s.w_got    = 1'b0;
            next_s.bresp    = SLTX_RESP_OKAY;
            case (s.awaddr)
                SLTX_MAINT_OFS: begin
                    if (s.wstrb[0]) begin
                        next_s.proto_ddcmp = s.wdata[SLTX_PROTO_BIT];
                    end
                end
                SLTX_OUT_OFS: begin
                    if (s.wstrb[0]) begin
                        next_s.hold[7:0] = s.wdata[7:0];
                        next_s.hold_full = 1'b1;
                        next_s.tx_done   = 1'b0;
                    end
                    if (s.wstrb[1]) begin
                        next_s.hold[9:8] = s.wdata[SLTX_EOM_BIT:SLTX_SOM_BIT];
                    end
                end
                SLTX_STAT_OFS: begin
                    next_s.bresp = SLTX_RESP_OKAY;
                end
                default: begin
                    next_s.bresp = SLTX_RESP_SLVERR;
                end
            endcase
        end else if ((s.wr_state == SLTX_WR_RESP) & s_axi_bready_i) begin
            next_s.wr_state = SLTX_WR_COLLECT;
        end

        // Read channel
        if (s_axi_arvalid_i & s_axi_arready_o) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = SLTX_RESP_OKAY;
            case (s_axi_araddr_i)
                SLTX_MAINT_OFS: next_s.rdata = {31'h0, s.proto_ddcmp};
                SLTX_OUT_OFS:   next_s.rdata = {22'h0, s.hold};
                SLTX_STAT_OFS:  next_s.rdata = status;
                default: begin
                    next_s.rdata = 32'h0;
                    next_s.rresp = SLTX_RESP_SLVERR;
                end
            endcase
        end else if (s.rvalid & s_axi_rready_i) begin
            next_s.rvalid = 1'b0;
        end

        // Transmit bit time
        if (bit_edge) begin
            if (sync_buffer_strobe) begin
                next_s.sb.flag_request         = fd.flag_request;
                next_s.sb.check_request        = fd.check_request;
                next_s.sb.synced_sending_flag  = fd.activate_request;
                next_s.sb.start_of_message_bit = s.hold[SLTX_SOM_BIT];
                next_s.sb.end_of_message_bit   = s.hold[SLTX_EOM_BIT];
                next_s.sb.synced_abort         = s.data_late;
            end
            if (fd.done_preset) begin
                next_s.tx_done = 1'b1;
            end
            if (dd.buffer_to_shift_load) begin
                next_s.shreg = s.hold[7:0];
                if (s.hold_full) begin
                    // A word written in this cycle stays pending
                    next_s.hold_full = wr_out;
                    next_s.tx_done   = 1'b1;
                end else if (s.sb.synced_sending_flag) begin
                    next_s.data_late = 1'b1;
                end
            end else if (dd.shift_clock_qualifier) begin
                next_s.shreg = {1'b0, s.shreg[7:1]};
            end
            if (~s.sb.synced_sending_flag) begin
                next_s.bit_count = '0;
                next_s.crc       = SLTX_CRC_INIT;
            end else begin
                if (pc.bit_counter_enable) begin
                    next_s.bit_count = s.bit_count + 3'h1;
                end
                if (dd.crc_clock_enable) begin
                    crc_fb = pc.check_select ? 1'b0 : (s.crc[15] ^ dd.serial_tx_bit);
                    next_s.crc = {s.crc[14:0], 1'b0} ^ (crc_fb ? SLTX_CRC_POLY : 16'h0);
                end
            end
            // Line idles at mark until the sync buffer shows sending
            next_s.txd = s.data_late | dd.serial_tx_bit | ~s.sb.synced_sending_flag;
            if (next_s.txd) begin
                if (s.ones != SLTX_ONES_6) begin
                    next_s.ones = s.ones + 3'h1;
                end
            end else begin
                next_s.ones = '0;
            end
        end

        // Software clears after hardware sets; a same-cycle set of data_late or tx_done wins, a sync buffer clear wins
        if (wr_maint & s.wdata[SLTX_SBCLR_BIT]) begin
            next_s.sb = '0;
        end
        if (wr_maint & s.wdata[SLTX_LATECLR_BIT] & ~(bit_edge & next_s.data_late & ~s.data_late)) begin
            next_s.data_late = 1'b0;
        end
        if (wr_out & bit_edge & (fd.done_preset | (dd.buffer_to_shift_load & s.hold_full))) begin
            next_s.tx_done = 1'b1;
        end
    end

    // ========================================================================
    // Registers
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            s          <= '0;
            s.crc      <= SLTX_CRC_INIT;
            s.txd      <= 1'b1;
            s.wr_state <= SLTX_WR_COLLECT;
        end else begin
            s <= next_s;
        end
    end
endmodule : sltx_sequencer

// file: shared/sltx_pkg.sv
// Purpose: Shared constants and types of the synchronous line transmit sequencer.
// Assumes: 32-bit AXI4-Lite register bus, one system clock.
// Notes:   Offsets are byte addresses of aligned words.
// ============================================================================
// Package
package sltx_pkg;
    // ========================================================================
    // Register map
    localparam int         SLTX_AW          = 4;
    localparam logic [3:0] SLTX_MAINT_OFS   = 4'h0;
    localparam logic [3:0] SLTX_OUT_OFS     = 4'h4;
    localparam logic [3:0] SLTX_STAT_OFS    = 4'h8;
    localparam int         SLTX_PROTO_BIT   = 0;
    localparam int         SLTX_SBCLR_BIT   = 1;
    localparam int         SLTX_LATECLR_BIT = 2;
    localparam int         SLTX_SOM_BIT     = 8;
    localparam int         SLTX_EOM_BIT     = 9;
    localparam logic [1:0] SLTX_RESP_OKAY   = 2'h0;
    localparam logic [1:0] SLTX_RESP_SLVERR = 2'h2;
    // ========================================================================
    // Transmit path constants
    localparam logic [2:0]  SLTX_BIT_MAX  = 3'h7;
    localparam logic [2:0]  SLTX_ONES_5   = 3'h5;
    localparam logic [2:0]  SLTX_ONES_6   = 3'h6;
    localparam logic [15:0] SLTX_CRC_POLY = 16'h1021;
    localparam logic [15:0] SLTX_CRC_INIT = 16'hffff;
    // ========================================================================
    // Bus write phases
    typedef enum logic [0:0] {
        SLTX_WR_COLLECT = 1'b0,
        SLTX_WR_RESP    = 1'b1
    } sltx_wr_e;
    // ========================================================================
    // Table outputs and the sync buffer
    typedef struct packed {
        logic flag_request;
        logic check_request;
        logic activate_request;
        logic done_preset;
    } sltx_fd_s;
    typedef struct packed {
        logic space_insert;
        logic check_select;
        logic shift_select;
        logic bit_counter_enable;
    } sltx_pc_s;
    typedef struct packed {
        logic shift_clock_qualifier;
        logic crc_clock_enable;
        logic buffer_to_shift_load;
        logic serial_tx_bit;
    } sltx_dd_s;
    typedef struct packed {
        logic flag_request;
        logic check_request;
        logic synced_sending_flag;
        logic start_of_message_bit;
        logic end_of_message_bit;
        logic synced_abort;
    } sltx_sync_s;
    // Status word, low bits first from the right
    typedef struct packed {
        logic [11:0] zero;
        logic [2:0]  ones;
        logic [2:0]  bit_count;
        logic        hold_full;
        logic        data_late;
        logic        tx_done;
        logic        serial_tx_bit;
        logic [3:0]  zero_b;
        sltx_sync_s  sync_buffer;
    } sltx_status_s;
endpackage : sltx_pkg

// file: verif/sltx_seq_asserts.sv
// Purpose: Port checker of the transmit sequencer.
// Assumes: Bound to the top module; one clock domain.
// Notes:   Serial changes only near a bit clock rise.
// ============================================================================
// Checker
module sltx_seq_asserts
    import sltx_pkg::*;
(
    // Clock and reset
    input wire logic        clk_sys_i,
    input wire logic        rst_i,
    // Modem side
    input wire logic        tx_clk_i,
    input wire logic        serial_tx_o,
    // Bus handshakes
    input wire logic        s_axi_awvalid_i,
    input wire logic        s_axi_awready_o,
    input wire logic        s_axi_wvalid_i,
    input wire logic        s_axi_wready_o,
    input wire logic [1:0]  s_axi_bresp_o,
    input wire logic        s_axi_bvalid_o,
    input wire logic        s_axi_bready_i,
    input wire logic        s_axi_arvalid_i,
    input wire logic        s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0]  s_axi_rresp_o,
    input wire logic        s_axi_rvalid_o,
    input wire logic        s_axi_rready_i
);
    logic       tx_q;
    logic [3:0] since_rise;
    // Cycles since the bit clock last rose, saturating
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            tx_q       <= 1'b0;
            since_rise <= 4'hf;
        end else begin
            tx_q <= tx_clk_i;
            if (tx_clk_i && !tx_q) begin
                since_rise <= 4'h0;
            end else if (since_rise != 4'hf) begin
                since_rise <= since_rise + 4'h1;
            end
        end
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sequence s_wr_both;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid_i && s_axi_arready_o;
    endsequence
    a_serial_at_strobe: assert property ($changed(serial_tx_o) |-> since_rise <= 4'h6)
        else $error("serial changed away from a bit strobe");
    a_reset_mark: assert property ($fell(rst_i) |-> serial_tx_o [*2])
        else $error("serial not mark after reset");
    a_write_answer: assert property (s_wr_both |=> ##1 s_axi_bvalid_o)
        else $error("write response late");
    a_bresp_holds: assert property (s_axi_bvalid_o && !s_axi_bready_i
        |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped");
    a_bvalid_drops: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
        else $error("write response repeated");
    a_write_blocked: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
        else $error("write taken during response");
    a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid_o)
        else $error("read response late");
    a_rdata_holds: assert property (s_axi_rvalid_o && !s_axi_rready_i
        |=> s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
        else $error("read response dropped");
    a_read_single: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("read taken during response");
endmodule : sltx_seq_asserts

bind sltx_sequencer sltx_seq_asserts sltx_seq_asserts_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .tx_clk_i(tx_clk_i), .serial_tx_o(serial_tx_o),
    .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
    .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rready_i(s_axi_rready_i)
);

// file: verif/sltx_modem_model.sv
// Purpose: Behavioural modem: transmit bit clock and line watcher.
// Assumes: Half period unrelated in phase to the system clock.
// Notes:   The bit clock stands low while run_i is low.
// ============================================================================
// Modem model
module sltx_modem_model #(
    parameter int HALF_NS = 203
) (
    // Control
    input  wire logic run_i,
    input  wire logic serial_i,
    // Modem outputs
    output logic      tx_clk_o,
    output int        spaces_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        tx_clk_o = 1'b0;
        forever begin
            #(HALF_NS);
            tx_clk_o = run_i ? ~tx_clk_o : 1'b0;
        end
    end
    // Count spaces seen on the line at each bit clock
    initial begin
        spaces_o = 0;
        forever begin
            @(posedge tx_clk_o);
            if (serial_i !== 1'b1) begin
                spaces_o = spaces_o + 1;
            end
        end
    end
endmodule : sltx_modem_model

// file: verif/sltx_sequencer_tb_top.sv
// Purpose: Self-checking bench of the transmit sequencer.
// Assumes: Modem model makes the bit clock; bus tasks speak AXI4-Lite.
// Notes:   Status masks follow the status word layout.
// ============================================================================
// Bench
module sltx_sequencer_tb_top
    import sltx_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] M_ABORT = 32'h1;
    localparam logic [31:0] M_MSG   = 32'h6;
    localparam logic [31:0] M_SEND  = 32'h8;
    localparam logic [31:0] M_DONE  = 32'h800;
    localparam logic [31:0] M_LATE  = 32'h1000;
    localparam logic [31:0] M_FULL  = 32'h2000;
    logic clk_sys_i, rst_i, tx_clk_i, clear_to_send_i, data_set_ready_i, crc_disable_i;
    logic table_disable_test_i, serial_tx_o, run;
    logic [SLTX_AW-1:0] s_axi_awaddr_i, s_axi_araddr_i;
    logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o;
    logic s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
    logic [31:0] s_axi_wdata_i, s_axi_rdata_o, st;
    logic [3:0]  s_axi_wstrb_i;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, resp;
    logic [7:0]  char;
    int          spaces, sp, mismatches, cmp_count, seed;
    sltx_sequencer sltx_sequencer_inst (.*);
    sltx_modem_model sltx_modem_model_inst (.run_i(run), .serial_i(serial_tx_o),
        .tx_clk_o(tx_clk_i), .spaces_o(spaces));
    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    task end_sim();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task axi_wr(input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            n++;
            if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
        end while (s_axi_bvalid_o !== 1'b1 && n < 50);
        resp = s_axi_bresp_o;
        s_axi_bready_i <= 1'b0;
        chk(32'(n < 50), 32'h1);
        if (n >= 50) begin
            end_sim();
        end
    endtask : axi_wr
    task axi_rd(input logic [3:0] a);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            n++;
            if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
        end while (s_axi_rvalid_o !== 1'b1 && n < 50);
        st = s_axi_rdata_o;
        resp = s_axi_rresp_o;
        s_axi_rready_i <= 1'b0;
        chk(32'(n < 50), 32'h1);
        if (n >= 50) begin
            end_sim();
        end
    endtask : axi_rd
    task bits(input int n);
        repeat (n * 11) @(posedge clk_sys_i);
    endtask : bits
    task poll(input logic [31:0] m, input logic [31:0] v);
        int n;
        n = 0;
        do begin
            axi_rd(SLTX_STAT_OFS);
            n++;
        end while ((st & m) !== v && n < 400);
        chk(st & m, v);
        if ((st & m) !== v) begin
            end_sim();
        end
    endtask : poll
    function automatic int zeros8(input logic [7:0] c);
        return 8 - $countones(c);
    endfunction : zeros8
    initial begin
        #3ms;
        mismatches++;
        end_sim();
    end
    initial begin
        {rst_i, run, s_axi_wstrb_i} = {2'b11, 4'hf};
        {clear_to_send_i, data_set_ready_i, crc_disable_i, table_disable_test_i} = 4'h0;
        {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = '0;
        {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
        {mismatches, cmp_count, seed} = {32'h0, 32'h0, 32'h45c67f66};
        repeat (3) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        crc_disable_i <= 1'($random(seed));
        char = 8'($random(seed)) & 8'hfe;
        chk(32'(serial_tx_o), 32'h1);
        axi_wr(4'hc, 32'h1);
        chk(32'(resp), 32'(SLVERR_EXP()));
        axi_rd(4'hc);
        chk(st, 32'h0);
        chk(32'(resp), 32'(SLVERR_EXP()));
        axi_wr(SLTX_STAT_OFS, 32'hffffffff);
        chk(32'(resp), 32'(SLTX_RESP_OKAY));
        for (int p = 0; p < 2; p++) begin
            axi_wr(SLTX_MAINT_OFS, 32'(p));
            axi_rd(SLTX_MAINT_OFS);
            chk(st & 32'h1, 32'(p));
        end
        // Tables held off: nothing starts, silo bits still reach the buffer
        {table_disable_test_i, clear_to_send_i, data_set_ready_i} <= 3'b111;
        axi_wr(SLTX_OUT_OFS, {22'h0, 2'b11, char});
        bits(20);
        axi_rd(SLTX_STAT_OFS);
        chk(st & (M_SEND | M_DONE), 0);
        chk(st & M_MSG, M_MSG);
        for (int k = 0; k < 3; k++) begin
            @(posedge clk_sys_i);
            {clear_to_send_i, data_set_ready_i} <= 2'(k);
            table_disable_test_i <= 1'b0;
            sp = spaces;
            bits(12);
            axi_rd(SLTX_STAT_OFS);
            chk(st & M_SEND, 0);
            chk(32'(spaces - sp), 0);
        end
        // Bit clock frozen: cleared buffer must not reload
        run <= 1'b0;
        bits(2);
        axi_wr(SLTX_MAINT_OFS, 32'h3);
        axi_rd(SLTX_STAT_OFS);
        chk(st & 32'h3f, 0);
        bits(4);
        axi_rd(SLTX_STAT_OFS);
        chk(st & 32'h3f, 0);
        run <= 1'b1;
        bits(4);
        axi_rd(SLTX_STAT_OFS);
        chk(st & M_MSG, M_MSG);
        // Permit given: send, then starve the silo
        {clear_to_send_i, data_set_ready_i} <= 2'b11;
        poll(M_SEND | M_DONE | M_FULL, M_SEND | M_DONE);
        // Next word, end of message off, written while the flag goes out
        sp = spaces;
        axi_wr(SLTX_OUT_OFS, {22'h0, 2'b00, char});
        axi_rd(SLTX_STAT_OFS);
        chk(st & (32'h2f | M_FULL | M_DONE), 32'h2e | M_FULL);
        poll(M_LATE, M_LATE);
        bits(1);
        chk(32'(spaces - sp), 32'(2 * zeros8(char)));
        sp = spaces;
        bits(10);
        chk(32'(spaces - sp), 0);
        poll(M_ABORT, M_ABORT);
        end_sim();
    end
    function automatic logic [1:0] SLVERR_EXP();
        return SLTX_RESP_SLVERR;
    endfunction : SLVERR_EXP
endmodule : sltx_sequencer_tb_top
